// ---- inc/uems_pkg.sv ----
package uems_pkg;

  // ==========================================================================
  // Register map (byte addresses, aligned words)
  localparam logic [11:0] UEMS_OFF_STATUS   = 12'h104;
  localparam logic [11:0] UEMS_OFF_MASK     = 12'h108;
  localparam logic [11:0] UEMS_OFF_SEVERITY = 12'h10c;
  localparam logic [11:0] UEMS_OFF_IRQ_MASK = 12'h130;

  // ==========================================================================
  // Field positions of the implemented error types
  localparam int UEMS_BIT_TRAIN = 0;
  localparam int UEMS_BIT_DLP   = 4;
  localparam int UEMS_BIT_PSN   = 12;
  localparam int UEMS_BIT_FCP   = 13;
  localparam int UEMS_BIT_CTO   = 14;
  localparam int UEMS_BIT_CA    = 15;
  localparam int UEMS_BIT_UC    = 16;
  localparam int UEMS_BIT_RO    = 17;
  localparam int UEMS_BIT_MTLP  = 18;
  localparam int UEMS_BIT_ECRC  = 19;
  localparam int UEMS_BIT_UR    = 20;
  localparam int UEMS_BIT_ACS   = 21;

  // Writable/implemented bits: 0, 4, 12..21
  localparam logic [31:0] UEMS_IMPL_BITS  = 32'h003f_f011;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] UEMS_MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] UEMS_SEV_RST    = 32'h0006_2011;
  localparam logic [31:0] UEMS_STAT_RST   = 32'h0000_0000;
  localparam logic [31:0] UEMS_IMASK_RST  = 32'h0000_0000;

  // ==========================================================================
  // APB request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } uems_apb_req_t;

  // Error report carrier toward the message and header log logic
  typedef struct packed {
    logic        valid;
    logic        fatal;
    logic [31:0] types;
  } uems_report_t;

  // Write-strobe expansion, used by every writable register
  function automatic logic [31:0] uems_strb_mask(input logic [3:0] strb);
    uems_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : uems_strb_mask

endpackage : uems_pkg

// ---- hdl/uems_apb_slave.sv ----
`timescale 1ns/1ps
module uems_apb_slave (
  input  wire logic                   clk,      // Core clock
  input  wire logic                   rst,      // Async reset, high
  input  wire uems_pkg::uems_apb_req_t req,     // APB request
  input  wire logic [31:0]            rd_data,  // Read mux value
  input  wire logic                   rd_hit,   // Address is mapped
  output logic                        wr_fire,  // Write commits now
  output logic                        rd_fire,  // Read commits now
  output logic                        pready,   // Registered ready
  output logic [31:0]                 prdata,   // Registered read data
  output logic                        pslverr   // Registered error
);
  import uems_pkg::*;

  logic        pready_d;
  logic        pready_q;
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;
  logic        pslverr_d;
  logic        pslverr_q;

  // ==========================================================================
  // Access phase
  // One wait state: ready is registered so pready, prdata and pslverr stay flop driven
  always_comb begin
    pready_d  = 1'b0;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (req.sel && req.enable && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !rd_hit;
      prdata_d  = (!req.write && rd_hit) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Commit on the same edge the master samples ready
  assign wr_fire = req.sel && req.enable && pready_q && req.write && rd_hit;
  assign rd_fire = req.sel && req.enable && pready_q && !req.write;
  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule : uems_apb_slave

// ---- hdl/uems_event_sync.sv ----
`timescale 1ns/1ps
module uems_event_sync (
  input  wire logic        clk,     // Core clock
  input  wire logic        rst,     // Async reset, high
  input  wire logic [31:0] ev_in,   // Raw event pulses/levels
  output logic      [31:0] ev_rise  // One-cycle pulse per rising event
);
  import uems_pkg::*;

  logic [31:0] s1_q;
  logic [31:0] s2_q;
  logic [31:0] s3_q;

  // ==========================================================================
  // Two-flop synchroniser plus edge history
  // Edge detect reads the second and third stages, never the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 32'h0000_0000;
      s2_q <= 32'h0000_0000;
      s3_q <= 32'h0000_0000;
    end else begin
      s1_q <= ev_in & UEMS_IMPL_BITS;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign ev_rise = s2_q & ~s3_q;

endmodule : uems_event_sync

// ---- hdl/uems_top.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Mask bit 0 set blocks header log and message for training errors; resets 0.
// - Mask bit 4 set blocks log and message for data link protocol errors; RW, resets 0.
// - Mask bit 12 set blocks log and message for poisoned TLPs.
// - Mask bit 13 set blocks log and message for flow control errors; resets 0.
// - Mask bit 14 set blocks log and message for completion timeouts; resets 0.
// - Mask bit 15 set blocks log and message for completer aborts; resets 0.
// - Mask bit 16 set blocks log and message for unexpected completions.
// - Mask bit 17 set blocks log and message for receiver overflows; resets 0.
// - Mask bit 18 set blocks log and message for malformed TLPs; resets 0.
// - Mask bit 19 set blocks log and message for ECRC errors; resets 0.
// - Mask bit 20 set blocks log and message for unsupported requests; resets 0.
// - Severity one means fatal, zero non-fatal; bits 0,4,13,17,18 reset to one.
// - Each error event sets a sticky status bit, cleared by writing one.
module uems_top (
  input  wire logic        REF_CLK,      // Core clock, 200 MHz
  input  wire logic        RST,          // Async reset, active high
  input  wire logic        PSEL,         // APB select
  input  wire logic        PENABLE,      // APB enable
  input  wire logic        PWRITE,       // APB direction
  input  wire logic [11:0] PADDR,        // APB byte address
  input  wire logic [31:0] PWDATA,       // APB write data
  input  wire logic [3:0]  PSTRB,        // APB byte strobes
  output logic             PREADY,       // APB ready
  output logic [31:0]      PRDATA,       // APB read data
  output logic             PSLVERR,      // APB error, unmapped address
  input  wire logic [31:0] ERR_EVENT,    // Error detector events, per bit
  output logic             LOG_STROBE,   // Capture header log, one cycle
  output logic [31:0]      LOG_TYPES,    // Types that are being logged
  output logic             MSG_FATAL,    // Send fatal message, one cycle
  output logic             MSG_NONFATAL, // Send non-fatal message, 1 cycle
  output logic [31:0]      MASK_OUT,     // Current mask register
  output logic [31:0]      SEV_OUT,      // Current severity register
  output logic             IRQ           // Level interrupt
);
  import uems_pkg::*;

  // ==========================================================================
  // Wiring
  uems_apb_req_t req;
  uems_report_t  rep_d;
  uems_report_t  rep_q;
  logic [31:0]   rd_data;
  logic          rd_hit;
  logic          wr_fire;
  logic          rd_fire;
  logic [31:0]   ev_rise;
  logic [31:0]   wmask;

  logic [31:0]   mask_d;
  logic [31:0]   mask_q;
  logic [31:0]   sev_d;
  logic [31:0]   sev_q;
  logic [31:0]   stat_d;
  logic [31:0]   stat_q;
  logic [31:0]   imask_d;
  logic [31:0]   imask_q;
  logic          irq_d;
  logic          irq_q;
  logic [31:0]   mask_o_q;
  logic [31:0]   sev_o_q;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR,
                 wdata: PWDATA, strb: PSTRB};

  // ==========================================================================
  // Bus slave
  uems_apb_slave u_apb (
    .clk     (REF_CLK),
    .rst     (RST),
    .req     (req),
    .rd_data (rd_data),
    .rd_hit  (rd_hit),
    .wr_fire (wr_fire),
    .rd_fire (),
    .pready  (PREADY),
    .prdata  (PRDATA),
    .pslverr (PSLVERR)
  );

  // ==========================================================================
  // Event input synchroniser
  // Detector logic may sit on another clock, so events are resynchronised
  uems_event_sync u_sync (
    .clk     (REF_CLK),
    .rst     (RST),
    .ev_in   (ERR_EVENT),
    .ev_rise (ev_rise)
  );

  // Read decode; only implemented bits can be nonzero
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (req.addr)
      UEMS_OFF_STATUS:   rd_data = stat_q;
      UEMS_OFF_MASK:     rd_data = mask_q;
      UEMS_OFF_SEVERITY: rd_data = sev_q;
      UEMS_OFF_IRQ_MASK: rd_data = imask_q;
      default:           rd_hit  = 1'b0;
    endcase
  end

  // ==========================================================================
  // Byte-lane merge shared by every read-write register
  function automatic logic [31:0] merge_wr(input logic [31:0] cur,
                                           input logic [31:0] wd,
                                           input logic [31:0] wm);
    merge_wr = (cur & ~wm) | (wd & wm);
  endfunction : merge_wr

  // ==========================================================================
  // Register file next state
  // Reserved bits are never stored, so they read zero and ignore writes
  always_comb begin
    wmask   = uems_strb_mask(req.strb) & UEMS_IMPL_BITS;
    mask_d  = mask_q;
    sev_d   = sev_q;
    imask_d = imask_q;
    stat_d  = stat_q;
    if (wr_fire) begin
      case (req.addr)
        UEMS_OFF_MASK:
          mask_d = merge_wr(mask_q, req.wdata, wmask);
        UEMS_OFF_SEVERITY:
          sev_d = merge_wr(sev_q, req.wdata, wmask);
        UEMS_OFF_IRQ_MASK:
          imask_d = merge_wr(imask_q, req.wdata, wmask);
        UEMS_OFF_STATUS:
          stat_d = stat_q & ~(req.wdata & wmask);
        default:
          stat_d = stat_q;
      endcase
    end
    // Set wins over a simultaneous write-one-to-clear
    stat_d = stat_d | (ev_rise & UEMS_IMPL_BITS);
  end

  // ==========================================================================
  // Report generation
  // Masked types neither log nor message, but still set status
  always_comb begin
    rep_d.types = ev_rise & ~mask_q & UEMS_IMPL_BITS;
    // Mask gating covers bits 4,13..21 the same way
    // Per-type gating also holds
    // and for the remaining types
    rep_d.valid = |rep_d.types;
    rep_d.fatal = |(rep_d.types & sev_q);
    irq_d       = |(stat_d & imask_d);
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mask_q   <= UEMS_MASK_RST;
      sev_q    <= UEMS_SEV_RST;
      stat_q   <= UEMS_STAT_RST;
      imask_q  <= UEMS_IMASK_RST;
      rep_q    <= '0;
      irq_q    <= 1'b0;
      mask_o_q <= UEMS_MASK_RST;
      sev_o_q  <= UEMS_SEV_RST;
    end else begin
      mask_q   <= mask_d;
      sev_q    <= sev_d;
      stat_q   <= stat_d;
      imask_q  <= imask_d;
      rep_q    <= rep_d;
      irq_q    <= irq_d;
      mask_o_q <= mask_d;
      sev_o_q  <= sev_d;
    end
  end

  // ==========================================================================
  // Outputs from flops; the two message strobes are decoded from rep_q
  // A mixed group sends one fatal message if any unmasked type is fatal
  assign LOG_STROBE   = rep_q.valid;
  assign LOG_TYPES    = rep_q.types;
  assign MSG_FATAL    = rep_q.valid && rep_q.fatal;
  assign MSG_NONFATAL = rep_q.valid && !rep_q.fatal;
  assign MASK_OUT     = mask_o_q;
  assign SEV_OUT      = sev_o_q;
  assign IRQ          = irq_q;

endmodule : uems_top

// ---- tb/uems_top_sva.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Checker on the top ports of the error mask bank
module uems_top_sva
  import uems_pkg::*;
(
  input wire logic        REF_CLK,      // Core clock
  input wire logic        RST,          // Async reset
  input wire logic        PSEL,         // APB select
  input wire logic        PENABLE,      // APB enable
  input wire logic        PREADY,       // APB ready
  input wire logic        PSLVERR,      // APB error
  input wire logic [31:0] ERR_EVENT,    // Error events
  input wire logic        LOG_STROBE,   // Header log capture
  input wire logic [31:0] LOG_TYPES,    // Logged types
  input wire logic        MSG_FATAL,    // Fatal message
  input wire logic        MSG_NONFATAL, // Non-fatal message
  input wire logic [31:0] MASK_OUT,     // Mask register
  input wire logic [31:0] SEV_OUT       // Severity register
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Access phase still waiting for the slave
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  // Fresh rise of an unmasked, implemented error type
  sequence s_new_event;
    (ERR_EVENT & ~$past(ERR_EVENT) & ~MASK_OUT & UEMS_IMPL_BITS) != 32'h0;
  endsequence
  // Reserved positions of both registers stay clear
  sequence s_rsvd_clear;
    ((MASK_OUT | SEV_OUT) & ~UEMS_IMPL_BITS) == 32'h0;
  endsequence
  // Logged types are present and none of them is masked
  sequence s_log_clean;
    LOG_TYPES != 32'h0 && (LOG_TYPES & MASK_OUT) == 32'h0;
  endsequence
  // Message class follows the severity of the logged types
  sequence s_class_ok;
    MSG_FATAL == ((LOG_TYPES & SEV_OUT) != 32'h0);
  endsequence

  a_ready_wait: assert property (s_access |=> PREADY)
    else $error("ready missing one cycle after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  a_rsvd_zero: assert property (s_rsvd_clear)
    else $error("reserved register bit set");
  a_log_unmasked: assert property (LOG_STROBE |-> s_log_clean)
    else $error("masked type logged");
  a_msg_with_log: assert property ((MSG_FATAL || MSG_NONFATAL) == LOG_STROBE)
    else $error("message and log capture disagree");
  a_msg_onehot: assert property (!(MSG_FATAL && MSG_NONFATAL))
    else $error("fatal and non-fatal together");
  a_fatal_by_sev: assert property (LOG_STROBE |-> s_class_ok)
    else $error("message class differs from severity");
  a_event_report: assert property (s_new_event |-> ##3 LOG_STROBE)
    else $error("unmasked event not reported in three cycles");
endmodule : uems_top_sva

bind uems_top uems_top_sva u_sva (.REF_CLK(REF_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ERR_EVENT(ERR_EVENT), .LOG_STROBE(LOG_STROBE), .LOG_TYPES(LOG_TYPES),
  .MSG_FATAL(MSG_FATAL), .MSG_NONFATAL(MSG_NONFATAL),
  .MASK_OUT(MASK_OUT), .SEV_OUT(SEV_OUT));

// ---- tb/uems_rc_model.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Root complex end: counts the error messages it receives
module uems_rc_model (
  input  wire logic clk,     // Core clock
  input  wire logic msg_fat, // Fatal message
  input  wire logic msg_nf,  // Non-fatal message
  output int        n_fat,   // Fatal count
  output int        n_nf     // Non-fatal count
);
  // No reset on purpose: the bench compares deltas across its resets
  always @(posedge clk) begin
    n_fat <= n_fat + int'(msg_fat === 1'h1);
    n_nf  <= n_nf + int'(msg_nf === 1'h1);
  end
endmodule : uems_rc_model

// ---- tb/test_uncorrectable_error_mask_severity.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Bench: mask, severity, status and interrupt over APB
module test_uncorrectable_error_mask_severity;
  import uems_pkg::*;
  typedef struct packed {
    logic [4:0] pos; // Error type bit
    logic       sev; // Severity written, also the fatal expectation
  } uems_row_t;
  localparam uems_row_t rows [12] = '{
    '{5'h00, 1'h0}, '{5'h04, 1'h1}, '{5'h0c, 1'h1}, '{5'h0d, 1'h0},
    '{5'h0e, 1'h1}, '{5'h0f, 1'h0}, '{5'h10, 1'h1}, '{5'h11, 1'h0},
    '{5'h12, 1'h1}, '{5'h13, 1'h0}, '{5'h14, 1'h1}, '{5'h15, 1'h0}};
  logic        REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        LOG_STROBE, MSG_FATAL, MSG_NONFATAL, IRQ, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, ERR_EVENT, LOG_TYPES, MASK_OUT, SEV_OUT;
  logic [31:0] rd, last_types;
  logic [3:0]  PSTRB;
  int          errors, comparisons, n_log, n_fat, n_nf;

  uems_top uut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .ERR_EVENT(ERR_EVENT), .LOG_STROBE(LOG_STROBE),
    .LOG_TYPES(LOG_TYPES), .MSG_FATAL(MSG_FATAL),
    .MSG_NONFATAL(MSG_NONFATAL), .MASK_OUT(MASK_OUT), .SEV_OUT(SEV_OUT),
    .IRQ(IRQ));
  uems_rc_model u_rc (.clk(REF_CLK), .msg_fat(MSG_FATAL),
    .msg_nf(MSG_NONFATAL), .n_fat(n_fat), .n_nf(n_nf));

  // 200 MHz clock
  initial begin
    REF_CLK = 1'h0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  // Header log captures as the bench sees them
  always @(posedge REF_CLK) begin
    if (LOG_STROBE === 1'h1) begin
      n_log <= n_log + 1;
      last_types <= LOG_TYPES;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic summarize;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge REF_CLK);
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    for (i = 0; i < 16 && PREADY !== 1'h1; i++) begin
      @(posedge REF_CLK);
    end
    if (i == 16) begin
      errors++;
      $display("[ERR] %0t no ready", $time);
      summarize();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb

  // Event held past the synchroniser; counts compared as deltas
  task automatic fire(input logic [31:0] ev, input logic el, input logic ef);
    int b0, b1, b2;
    b0 = n_log;
    b1 = n_fat;
    b2 = n_nf;
    ERR_EVENT <= ev;
    repeat (8) @(posedge REF_CLK);
    ERR_EVENT <= 32'h0;
    repeat (4) @(posedge REF_CLK);
    chk(32'(n_log - b0), {31'h0, el});
    chk(32'(n_fat - b1), {31'h0, ef});
    chk(32'(n_nf - b2), {31'h0, el & !ef});
    if (el) chk(last_types, ev);
  endtask : fire

  // ==========================================================================
  // Main sequence
  initial begin
    RST = 1'h1;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    PSTRB = 4'hf;
    ERR_EVENT = 32'h0;
    repeat (16) @(posedge REF_CLK);
    RST <= 1'h0;
    // Rows: masked type stays silent, unmasked one reports by severity
    foreach (rows[k]) begin
      apb(1'h1, UEMS_OFF_MASK, 32'h1 << rows[k].pos);
      fire(32'h1 << rows[k].pos, 1'h0, 1'h0);
      apb(1'h1, UEMS_OFF_MASK, 32'h0);
      apb(1'h1, UEMS_OFF_SEVERITY, {31'h0, rows[k].sev} << rows[k].pos);
      fire(32'h1 << rows[k].pos, 1'h1, rows[k].sev);
    end
    // Reset in mid-run restores both registers
    RST <= 1'h1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'h0;
    apb(1'h0, UEMS_OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    chk(MASK_OUT, 32'h0);
    apb(1'h0, UEMS_OFF_SEVERITY, 32'h0);
    chk(rd, 32'h0006_2011);
    chk(SEV_OUT, 32'h0006_2011);
    // Two types at once: one report, fatal wins
    fire(32'h0000_3000, 1'h1, 1'h1);
    // Reserved bits ignore writes
    apb(1'h1, UEMS_OFF_MASK, 32'hffff_ffff);
    apb(1'h0, UEMS_OFF_MASK, 32'h0);
    chk(rd, 32'h003f_f011);
    chk(MASK_OUT, 32'h003f_f011);
    apb(1'h1, UEMS_OFF_SEVERITY, 32'hffff_ffff);
    apb(1'h0, UEMS_OFF_SEVERITY, 32'h0);
    chk(rd, 32'h003f_f011);
    apb(1'h0, 12'h200, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Only lane 2 written: bits 23:16 clear, lower ones keep their value
    PSTRB <= 4'h4;
    apb(1'h1, UEMS_OFF_MASK, 32'h0);
    PSTRB <= 4'hf;
    apb(1'h0, UEMS_OFF_MASK, 32'h0);
    chk(rd, 32'h0000_f011);
    // Masked event still sets status; interrupt follows its mask
    fire(32'h1, 1'h0, 1'h0);
    apb(1'h0, UEMS_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_3001);
    apb(1'h1, UEMS_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h1);
    apb(1'h1, UEMS_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h0);
    apb(1'h1, UEMS_OFF_IRQ_MASK, 32'h1);
    apb(1'h1, UEMS_OFF_STATUS, 32'h1);
    apb(1'h0, UEMS_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_3000);
    chk({31'h0, IRQ}, 32'h0);
    summarize();
  end
endmodule : test_uncorrectable_error_mask_severity
